// >>> pkg/pcl_pkg.sv
// Shared constants for the parallel configuration load link.
// Assumes a 50 MHz system clock on the host side; nothing else.
package pcl_pkg;

    // ==========================================================
    // Link widths and timing
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int CLK_PERIOD_NS = 20;
    localparam int REQ_LOW_MIN_NS = 2000;
    // Least time, so round up
    localparam int REQ_LOW_CYC = (REQ_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESP_MAX_NS = 600;
    // Longest time, so round down
    localparam int RESP_MAX_CYC = RESP_MAX_NS / CLK_PERIOD_NS;
    localparam logic [2:0] LEAD_EDGES = 3'h4;
    localparam logic [2:0] PHASE_ZERO = 3'h0;

    // ==========================================================
    // Initialization clock sources and their frequency limits
    localparam logic [1:0] INIT_OSC = 2'h0;
    localparam logic [1:0] INIT_USER = 2'h1;
    localparam logic [1:0] INIT_LINK = 2'h2;
    localparam int OSC_MAX_KHZ = 12500;
    localparam int USER_MAX_PASSIVE_KHZ = 125000;
    localparam int USER_MAX_ACTIVE_KHZ = 100000;
    localparam int LINK_MAX_PASSIVE_KHZ = 125000;

    // ==========================================================
    // Host register map (byte addresses) and fields
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_DATA = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_LEN = 4'hc;
    localparam int CTRL_START = 0;
    localparam int CTRL_WIDE = 1;
    localparam int CTRL_ENC = 2;
    localparam int CTRL_COMP = 3;
    localparam int CTRL_INIT_LO = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Clock edges per data item for the active width and features
    function automatic logic [2:0] clk_ratio(input logic wide, input logic enc,
                                             input logic comp);
        logic [2:0] r;
        r = 3'h1;
        if (!wide) begin
            r = comp ? 3'h2 : 3'h1;
        end else if (comp) begin
            r = 3'h4;
        end else if (enc) begin
            r = 3'h2;
        end
        return r;
    endfunction

endpackage

// >>> pkg/pcl_link_if.sv
// Pins between the configuration host and the loading device.
// Assumes the bench joins the two modports; all pins are one-way.
`timescale 1ns/1ps
`default_nettype none
interface pcl_link_if;
    logic config_clock;
    logic config_req_n;
    logic status_n;
    logic config_done_flag;
    logic [15:0] data;
    logic wide;
    logic encrypt_on;
    logic compress_on;
    logic [1:0] init_sel;

    modport host (
        output config_clock, config_req_n, data, wide, encrypt_on, compress_on, init_sel,
        input status_n, config_done_flag
    );
    modport device (
        input config_clock, config_req_n, data, wide, encrypt_on, compress_on, init_sel,
        output status_n, config_done_flag
    );
endinterface
`default_nettype wire

// >>> core/pcl_device.sv
// Device end: takes a bitstream over the parallel load link.
// Assumes the host holds straps steady for a whole load and gives
// four lead clock edges before the first data item.
`timescale 1ns/1ps
`default_nettype none
module pcl_device
    import pcl_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    pcl_link_if.device LINK,
    input wire logic [15:0] LOAD_WORDS,
    output logic [15:0] WORD,
    output logic WORD_VALID,
    output logic LOADED,
    output logic [1:0] INIT_SRC,
    output logic INIT_SRC_BAD
);

    // ==========================================================
    // System clock side: request, status and done
    logic req_meta, req_sync;
    logic done_meta, done_sync;
    logic [1:0] init_meta, init_sync;
    logic done_link;
    logic link_rst;

    // Request pin into the system domain; reset value means requested
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            req_meta <= 1'b0;
            req_sync <= 1'b0;
        end else begin
            req_meta <= LINK.config_req_n;
            req_sync <= req_meta;
        end
    end

    // Done level from the link domain
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            done_meta <= 1'b0;
            done_sync <= 1'b0;
        end else begin
            done_meta <= done_link;
            done_sync <= done_meta;
        end
    end

    // Status follows the request within three system cycles
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            LINK.status_n <= 1'b0;
        end else begin
            LINK.status_n <= req_sync;
        end
    end

    // Done drops with the request even if the link clock is stopped
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            LINK.config_done_flag <= 1'b0;
            LOADED <= 1'b0;
        end else begin
            LINK.config_done_flag <= req_sync & done_sync;
            LOADED <= req_sync & done_sync;
        end
    end

    // Init clock choice; all three sources suit a passive load
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            init_meta <= INIT_OSC;
            init_sync <= INIT_OSC;
            INIT_SRC <= INIT_OSC;
            INIT_SRC_BAD <= 1'b0;
        end else begin
            init_meta <= LINK.init_sel;
            init_sync <= init_meta;
            INIT_SRC <= init_sync;
            INIT_SRC_BAD <= (init_sync != INIT_OSC) && (init_sync != INIT_USER)
                && (init_sync != INIT_LINK);
        end
    end

    // ==========================================================
    // Link clock side: capture data items
    // A low request clears this side at once, with or without edges
    assign link_rst = RST | ~LINK.config_req_n;

    logic [2:0] mode_meta, mode_sync;
    logic [15:0] len_meta, len_sync;
    logic [2:0] lead;
    logic [2:0] phase;
    logic [15:0] count;
    logic [2:0] ratio;

    // Straps and length pass two flops; the lead edges cover the delay
    always_ff @(posedge LINK.config_clock or posedge link_rst) begin
        if (link_rst) begin
            mode_meta <= 3'h0;
            mode_sync <= 3'h0;
            len_meta <= 16'h0000;
            len_sync <= 16'h0000;
        end else begin
            mode_meta <= {LINK.wide, LINK.encrypt_on, LINK.compress_on};
            mode_sync <= mode_meta;
            len_meta <= LOAD_WORDS;
            len_sync <= len_meta;
        end
    end

    assign ratio = clk_ratio(mode_sync[2], mode_sync[1], mode_sync[0]);

    // Lead edges, then one item per ratio edges, sampled on the first
    always_ff @(posedge LINK.config_clock or posedge link_rst) begin
        if (link_rst) begin
            lead <= 3'h0;
            phase <= PHASE_ZERO;
            count <= 16'h0000;
            WORD <= 16'h0000;
            WORD_VALID <= 1'b0;
            done_link <= 1'b0;
        end else begin
            WORD_VALID <= 1'b0;
            if (lead != LEAD_EDGES) begin
                lead <= lead + 3'h1;
            end else if (!done_link) begin
                if (phase == PHASE_ZERO) begin
                    // Byte mode uses the low lane only
                    WORD <= mode_sync[2] ? LINK.data : {8'h00, LINK.data[BYTE_W-1:0]};
                    WORD_VALID <= 1'b1;
                    count <= count + 16'h0001;
                    done_link <= (count + 16'h0001) == len_sync;
                end
                phase <= (phase == ratio - 3'h1) ? PHASE_ZERO : phase + 3'h1;
            end
        end
    end

endmodule
`default_nettype wire

// >>> core/pcl_host.sv
// Host end: drives a bitstream into the device over the load link,
// under software control through AXI4-Lite registers.
// Assumes CLK at 50 MHz; the link clock is made here by a divider.
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pcl_host
    import pcl_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    pcl_link_if.host LINK,
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PULSE = 3'b001,
        ST_WAIT = 3'b011,
        ST_LEAD = 3'b010,
        ST_STREAM = 3'b110,
        ST_FINISH = 3'b111
    } state_t;

    state_t state;
    logic [15:0] len;
    logic ctrl_wide, ctrl_enc, ctrl_comp;
    logic [1:0] ctrl_init;
    logic [15:0] word_buf;
    logic word_full;
    logic [15:0] sent;
    logic [6:0] pulse_cnt;
    logic [2:0] lead;
    logic [2:0] phase;
    logic loaded;
    logic [2:0] ratio;
    logic status_meta, status_sync, done_meta, done_sync;
    logic wr_fire, wr_data, start;

    // ==========================================================
    // Returning pins, two flops each
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            status_meta <= 1'b0;
            status_sync <= 1'b0;
            done_meta <= 1'b0;
            done_sync <= 1'b0;
        end else begin
            status_meta <= LINK.status_n;
            status_sync <= status_meta;
            done_meta <= LINK.config_done_flag;
            done_sync <= done_meta;
        end
    end

    // ==========================================================
    // AXI4-Lite write channel
    // Both halves taken together; a data write waits while the buffer
    // is full, which is the back-pressure on software
    assign wr_fire = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID
        && !(S_AXI_AWADDR[3:0] == REG_DATA && word_full);
    assign wr_data = wr_fire && S_AXI_AWADDR[3:0] == REG_DATA;
    assign start = wr_fire && S_AXI_AWADDR[3:0] == REG_CTRL && S_AXI_WDATA[CTRL_START];

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
        end else begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
            if (wr_fire && !S_AXI_AWREADY) begin
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY <= 1'b1;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= (S_AXI_AWADDR[3:0] == REG_STATUS) ? RESP_SLVERR : RESP_OKAY;
            end
        end
    end

    // Control and length registers
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl_wide <= 1'b0;
            ctrl_enc <= 1'b0;
            ctrl_comp <= 1'b0;
            ctrl_init <= INIT_OSC;
            len <= 16'h0000;
        end else if (wr_fire && !S_AXI_AWREADY && S_AXI_WSTRB[0]) begin
            if (S_AXI_AWADDR[3:0] == REG_CTRL) begin
                ctrl_wide <= S_AXI_WDATA[CTRL_WIDE];
                ctrl_enc <= S_AXI_WDATA[CTRL_ENC];
                ctrl_comp <= S_AXI_WDATA[CTRL_COMP];
                ctrl_init <= S_AXI_WDATA[CTRL_INIT_LO +: 2];
            end else if (S_AXI_AWADDR[3:0] == REG_LEN) begin
                len <= S_AXI_WDATA[15:0];
            end
        end
    end

    // ==========================================================
    // AXI4-Lite read channel, answer one cycle after the address
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= 1'b0;
            if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end else if (S_AXI_ARVALID && !S_AXI_RVALID && !S_AXI_ARREADY) begin
                S_AXI_ARREADY <= 1'b1;
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= RESP_OKAY;
                if (S_AXI_ARADDR[3:0] == REG_CTRL) begin
                    S_AXI_RDATA <= {26'h0, ctrl_init, ctrl_comp, ctrl_enc, ctrl_wide, 1'b0};
                end else if (S_AXI_ARADDR[3:0] == REG_STATUS) begin
                    S_AXI_RDATA <= {sent, 9'h0, state, done_sync, status_sync,
                                    word_full, state != ST_IDLE};
                end else if (S_AXI_ARADDR[3:0] == REG_LEN) begin
                    S_AXI_RDATA <= {16'h0, len};
                end else if (S_AXI_ARADDR[3:0] == REG_DATA) begin
                    S_AXI_RDATA <= {16'h0, word_buf};
                end else begin
                    S_AXI_RDATA <= 32'h0000_0000;
                    S_AXI_RRESP <= RESP_SLVERR;
                end
            end
        end
    end

    // ==========================================================
    // Load sequence
    assign ratio = clk_ratio(ctrl_wide, ctrl_enc, ctrl_comp);

    // Straps follow the control register
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            LINK.wide <= 1'b0;
            LINK.encrypt_on <= 1'b0;
            LINK.compress_on <= 1'b0;
            LINK.init_sel <= INIT_OSC;
        end else begin
            LINK.wide <= ctrl_wide;
            LINK.encrypt_on <= ctrl_enc;
            LINK.compress_on <= ctrl_comp;
            LINK.init_sel <= ctrl_init;
        end
    end

    // State, request pin and the pulse timer
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state <= ST_IDLE;
            LINK.config_req_n <= 1'b1;
            pulse_cnt <= 7'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        state <= ST_PULSE;
                        LINK.config_req_n <= 1'b0;
                        pulse_cnt <= 7'h00;
                    end
                end
                ST_PULSE: begin
                    pulse_cnt <= pulse_cnt + 7'h01;
                    if (pulse_cnt == 7'(REQ_LOW_CYC - 1)) begin
                        LINK.config_req_n <= 1'b1;
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (status_sync) begin
                        state <= ST_LEAD;
                    end
                end
                ST_LEAD: begin
                    if (lead == LEAD_EDGES) begin
                        state <= ST_STREAM;
                    end
                end
                ST_STREAM: begin
                    // Wait for the last item's edges before leaving the stream
                    if (sent == len && phase == PHASE_ZERO && !LINK.config_clock
                        && !loaded) begin
                        state <= ST_FINISH;
                    end
                end
                ST_FINISH: begin
                    // Device stays loaded; host returns to rest
                    if (done_sync || !status_sync) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Link clock divider: it only runs while edges are wanted, so a
    // missing word stalls the clock low instead of losing a phase
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            LINK.config_clock <= 1'b0;
            lead <= 3'h0;
            phase <= PHASE_ZERO;
            loaded <= 1'b0;
            sent <= 16'h0000;
            LINK.data <= 16'h0000;
        end else if (state == ST_LEAD) begin
            // Stop toggling once the lead edges are out, so no extra rise
            if (lead != LEAD_EDGES) begin
                LINK.config_clock <= ~LINK.config_clock;
            end
            if (LINK.config_clock) begin
                lead <= lead + 3'h1;
            end
        end else if (state == ST_STREAM) begin
            if (LINK.config_clock) begin
                LINK.config_clock <= 1'b0;
            end else if (phase != PHASE_ZERO || loaded) begin
                LINK.config_clock <= 1'b1;
                loaded <= 1'b0;
                phase <= (phase == ratio - 3'h1) ? PHASE_ZERO : phase + 3'h1;
            end else if (word_full && sent != len) begin
                // Data set one cycle before the rising edge
                LINK.data <= word_buf;
                loaded <= 1'b1;
                sent <= sent + 16'h0001;
            end
        end else begin
            LINK.config_clock <= 1'b0;
            phase <= PHASE_ZERO;
            loaded <= 1'b0;
            if (state != ST_FINISH) begin
                lead <= 3'h0;
                sent <= 16'h0000;
            end
        end
    end

    // Single word buffer; a new write cannot arrive while full
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            word_buf <= 16'h0000;
            word_full <= 1'b0;
        end else if (wr_data && !S_AXI_AWREADY) begin
            word_buf <= S_AXI_WDATA[15:0];
            word_full <= 1'b1;
        end else if (state == ST_STREAM && !LINK.config_clock && phase == PHASE_ZERO
                     && !loaded && word_full && sent != len) begin
            word_full <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// >>> tb/pcl_link_monitor.sv
// Checker for the parallel load link pins between host and device.
// Assumes one CLK drives both ends and RST clears both.
`timescale 1ns/1ps
`default_nettype none
module pcl_link_monitor
    import pcl_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic config_clock,
    input wire logic config_req_n,
    input wire logic status_n,
    input wire logic config_done_flag,
    input wire logic [15:0] data,
    input wire logic wide,
    input wire logic encrypt_on,
    input wire logic compress_on,
    input wire logic [1:0] init_sel
);
    // ==========================================================
    // Helper logic
    localparam int RESP_CYC = RESP_MAX_CYC;
    logic prev_clk;
    logic [15:0] prev_data;
    logic seen;
    logic [3:0] rises;
    logic [7:0] low_cnt;
    logic rise;
    logic [2:0] ratio;
    // Expected edges per item, worked out here rather than borrowed
    assign ratio = !wide ? (compress_on ? 3'h2 : 3'h1) :
                   (compress_on ? 3'h4 : (encrypt_on ? 3'h2 : 3'h1));
    assign rise = config_clock && !prev_clk;
    // Previous pin values
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            prev_clk <= 1'h0;
            prev_data <= 16'h0;
        end else begin
            prev_clk <= config_clock;
            prev_data <= data;
        end
    end
    // Link edges since the last item; lead edges are skipped by seen
    always_ff @(posedge CLK or posedge RST) begin
        if (RST || !config_req_n) begin
            rises <= 4'h0;
            seen <= 1'h0;
        end else if (data != prev_data) begin
            rises <= {3'h0, rise};
            seen <= 1'h1;
        end else if (rise && rises != 4'hf) begin
            rises <= rises + 4'h1;
        end
    end
    // Length of the request pulse, saturating
    always_ff @(posedge CLK or posedge RST) begin
        if (RST || config_req_n) begin
            low_cnt <= 8'h0;
        end else if (low_cnt != 8'hff) begin
            low_cnt <= low_cnt + 8'h1;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    a_req_low_width:
        assert property ($rose(config_req_n) |-> low_cnt >= 8'(REQ_LOW_CYC))
        else $error("request pulse too short");
    a_done_drops:
        assert property ($fell(config_req_n) |-> ##[0:RESP_CYC] !config_done_flag)
        else $error("done did not fall after request");
    a_status_drops:
        assert property ($fell(config_req_n) |-> ##[0:RESP_CYC] !status_n)
        else $error("status did not fall after request");
    a_item_ratio:
        assert property (config_req_n && seen && data != prev_data |-> rises == {1'h0, ratio})
        else $error("wrong link edge count per item");
    a_straps_steady:
        assert property (status_n && config_req_n && !config_done_flag |=>
            $stable({wide, encrypt_on, compress_on}))
        else $error("straps changed during load");
    a_done_holds:
        assert property (config_done_flag && config_req_n |=> config_done_flag)
        else $error("done dropped without request");
    a_done_after_req:
        assert property ($rose(config_done_flag) |-> config_req_n && status_n)
        else $error("done rose during request");
    a_clock_needs_status:
        assert property ($rose(config_clock) |-> status_n && config_req_n)
        else $error("link clock ran without device ready");
    c_load_done: cover property ($rose(config_done_flag));
    c_ratio_four: cover property (seen && data != prev_data && ratio == 3'h4);
    c_reload: cover property ($fell(config_req_n) && config_done_flag);
    c_link_init: cover property (init_sel == INIT_LINK);
endmodule
`default_nettype wire

// >>> tb/parallel_config_load_port_bench.sv
// Bench joining host and device over the load link, driven over AXI4-Lite.
// Assumes both ends share CLK at 50 MHz; the host makes the link clock.
`timescale 1ns/1ps
`default_nettype none
module parallel_config_load_port_bench
    import pcl_pkg::*;
;
    // ==========================================================
    // Signals and instances
    logic CLK, RST;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp, init_src;
    logic [15:0] word;
    logic word_valid, loaded, init_bad;
    int n_errors = 0, checks = 0, cyc = 0, nrise = 0, nv = 0, lowc = 0, low_len = 0;
    int at_q[4];
    logic [15:0] cap[4];
    // Edges per item, indexed by {comp, enc, wide}
    localparam logic [2:0] RATIO_TAB [8] = '{3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h2, 3'h4};
    pcl_link_if link();
    pcl_host pcl_host_i (.CLK(CLK), .RST(RST), .LINK(link.host),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    pcl_device pcl_device_i (.CLK(CLK), .RST(RST), .LINK(link.device), .LOAD_WORDS(16'h0003),
        .WORD(word), .WORD_VALID(word_valid), .LOADED(loaded), .INIT_SRC(init_src),
        .INIT_SRC_BAD(init_bad));
    pcl_link_monitor pcl_link_monitor_i (.CLK(CLK), .RST(RST), .config_clock(link.config_clock),
        .config_req_n(link.config_req_n), .status_n(link.status_n),
        .config_done_flag(link.config_done_flag), .data(link.data), .wide(link.wide),
        .encrypt_on(link.encrypt_on), .compress_on(link.compress_on), .init_sel(link.init_sel));

    // ==========================================================
    // Clock, watchdog and pin observers
    initial begin
        CLK = 1'h0;
        forever #10 CLK = ~CLK;
    end
    // Watchdog also measures the request pulse
    always @(posedge CLK) begin
        cyc++;
        if (link.config_req_n === 1'h0) begin
            lowc++;
        end else if (lowc != 0) begin
            low_len = lowc;
            lowc = 0;
        end
        if (cyc == 40000) begin
            n_errors++;
            $display("[FAIL] %0t: timeout", $time);
            conclude();
        end
    end
    // Pulse is seen one link edge late; the gap between items still holds
    always @(posedge link.config_clock) begin
        nrise++;
        if (word_valid === 1'h1 && nv < 4) begin
            cap[nv] = word;
            at_q[nv] = nrise;
            nv++;
        end
    end

    // ==========================================================
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'h0;
        @(posedge CLK);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (done !== 1'h1) begin
            @(posedge CLK);
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
            done = bvalid;
            r = bresp;
        end
        bready <= 1'h0;
    endtask
    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'h0;
        @(posedge CLK);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        while (done !== 1'h1) begin
            @(posedge CLK);
            if (arready === 1'h1) arvalid <= 1'h0;
            done = rvalid;
            d = rdata;
            r = rresp;
        end
        rready <= 1'h0;
    endtask
    // Source selection, including the illegal code
    task automatic init_test();
        logic [1:0] r;
        int n;
        for (int s = 0; s < 4; s++) begin
            axi_wr(32'(REG_CTRL), 32'(s) << CTRL_INIT_LO, r);
            n = 0;
            while (init_src !== 2'(s) && n < 20) begin
                @(posedge CLK);
                n++;
            end
            chk(init_src, 32'(s));
            chk(init_bad, 32'(s == 3));
        end
        $display("init source test done");
    endtask
    // One whole load with the given straps; items differ from every earlier load
    task automatic load_run(input int k, input logic [2:0] f);
        logic [1:0] r;
        logic [31:0] rd;
        logic [15:0] item[3];
        logic [15:0] m;
        int n;
        m = f[0] ? 16'hffff : 16'h00ff;
        for (int i = 0; i < 3; i++) item[i] = 16'h5a00 + 16'(k * 4 + i + 1);
        nv = 0;
        axi_wr(32'(REG_LEN), 32'h3, r);
        axi_wr(32'(REG_CTRL), {28'h0, f, 1'h1}, r);
        for (int i = 0; i < 3; i++) axi_wr(32'(REG_DATA), {16'h0, item[i]}, r);
        n = 0;
        while (loaded !== 1'h1 && n < 3000) begin
            @(posedge CLK);
            n++;
        end
        chk(loaded, 32'h1);
        chk(32'(low_len >= REQ_LOW_CYC), 32'h1);
        chk(32'(nv >= 2), 32'h1);
        chk(cap[0] & m, item[0] & m);
        chk(cap[1] & m, item[1] & m);
        chk(word & m, item[2] & m);
        chk(32'(at_q[1] - at_q[0]), 32'(RATIO_TAB[f]));
        axi_rd(32'(REG_STATUS), rd, r);
        chk(rd[31:16], 32'h3);
        chk(rd[3], 32'h1);
        $display("load %0d straps %b done", k, f);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] rd;
        logic [1:0] r;
        RST = 1'h1;
        {awaddr, wdata, araddr} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        repeat (4) @(posedge CLK);
        RST <= 1'h0;
        // Unaligned read and a write to the read-only status word
        axi_rd(32'h2, rd, r);
        chk(r, RESP_SLVERR);
        chk(rd, 32'h0);
        axi_wr(32'(REG_STATUS), 32'h0, r);
        chk(r, RESP_SLVERR);
        $display("register access test done");
        init_test();
        // Every width and feature combination, back to back
        for (int k = 0; k < 8; k++) load_run(k, 3'(k));
        conclude();
    end
endmodule
`default_nettype wire
